// >>> design/configurable_logic_module.sv
// Four configurable logic units with look-up tables, optional flops,
// input selectors, carry chain and output routing.
// Assumes one core clock, a synchronous reset and port pins that arrive
// asynchronously; peripheral inputs come from logic on core_clk.

// What this block does
// - Four independent software-configured logic units
// - Three-input table, any of 256 functions
// - First and second inputs from 16-way selectors
// - Third input is carry from preceding unit
// - Selectors pick pins or any unit output
// - Unit outputs route to pins or peripherals
// - Each unit flop samples its table output
// - Flop clock source from clock-select field
// - Bypass bit sends table result straight out
// - Table index: first MSB, carry LSB
// - Set/reset latch holds, resets, sets
// - Set/reset latch wiring, function byte 0x74
// - Unit outputs always definite high or low
// - Data latch wiring, function byte 0xAC
// - Data latch transparent high, holds low
// - Preceding table buffers its first input
// - Latches use table feedback, flop unused
// - Units run continuously without processor
module configurable_logic_module
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [logic_unit_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Port pins and peripheral inputs
  input wire logic [logic_unit_pkg::PIN_COUNT-1:0] pinIn,
  input wire logic [logic_unit_pkg::PERIPH_COUNT-1:0] periphIn,
  // Unit outputs
  output logic [logic_unit_pkg::NUM_UNITS-1:0] pinOut,
  output logic [logic_unit_pkg::NUM_UNITS-1:0] pinOe,
  output logic [logic_unit_pkg::NUM_UNITS-1:0] periphOut
);

  localparam int N = logic_unit_pkg::NUM_UNITS;
  localparam int P = logic_unit_pkg::PIN_COUNT;

  // Pin synchroniser stages
  logic [P-1:0] pinMeta;
  logic [P-1:0] pinSync2;
  logic [P-1:0] pinSync3;
  logic [P-1:0] pinClean;

  // Per-unit configuration
  logic [7:0] funcByte [N];
  logic [7:0] inputSel [N];
  logic [logic_unit_pkg::FCLK_SEL_W-1:0] flop_clock_select [N];
  logic [logic_unit_pkg::CTL_W-1:0] control [N];

  // Per-unit datapath
  logic [N-1:0] inA;
  logic [N-1:0] inB;
  logic [N-1:0] carry;
  logic [N-1:0] lutOut;
  logic [N-1:0] lutHeld;
  logic [N-1:0] flopQ;
  logic [N-1:0] unitOut;
  logic [N-1:0] outHeld;
  logic [N-1:0] prevA;
  logic [N-1:0] prevB;
  logic [N-1:0] prevCarry;
  logic [N-1:0] flopTick;

  // All 16 selector candidates: pins, held unit outputs, peripherals
  logic [15:0] candidates;

  logic [7:0] next_rdData;
  logic [7:0] statusWord;

  // Three-stage pin capture; a change is taken once stages two and
  // three agree, which rejects a value caught mid-transition.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pinMeta <= '0;
      pinSync2 <= '0;
      pinSync3 <= '0;
    end
    else
    begin
      pinMeta <= pinIn;
      pinSync2 <= pinMeta;
      pinSync3 <= pinSync2;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      pinClean <= '0;
    else
    begin
      for (int i = 0; i < P; i++)
      begin
        if (pinSync2[i] == pinSync3[i])
          pinClean[i] <= pinSync3[i];
      end
    end
  end

  // Unit feedback uses the held outputs so that a latch built from
  // table feedback never forms a combinational loop.
  assign candidates = {periphIn, outHeld, pinClean};

  // The ring would close from the last unit back to the first; that one
  // carry is taken from a held copy to keep the chain loop-free.
  always_comb
  begin
    for (int u = 0; u < N; u++)
    begin
      if (u == 0)
        carry[u] = lutHeld[N-1];
      else
        carry[u] = lutOut[u-1];
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gen_unit
      localparam logic [logic_unit_pkg::ADDR_W-1:0] BASE =
        logic_unit_pkg::ADDR_W'(g * 4);
      logic hitUnit;

      assign hitUnit = regWrite &&
        (regAddr[logic_unit_pkg::ADDR_W-1:2] == BASE[4:2]);

      // Configuration registers, written by software only
      always_ff @(posedge core_clk)
      begin
        if (srst)
          funcByte[g] <= logic_unit_pkg::FUNCTION_RESET;
        else if (hitUnit &&
                 regAddr[1:0] == logic_unit_pkg::OFS_FUNCTION)
          funcByte[g] <= regWrData;
      end

      always_ff @(posedge core_clk)
      begin
        if (srst)
          inputSel[g] <= logic_unit_pkg::CONFIG_RESET;
        else if (hitUnit && regAddr[1:0] == logic_unit_pkg::OFS_CONFIG)
          inputSel[g] <= regWrData;
      end

      always_ff @(posedge core_clk)
      begin
        if (srst)
          flop_clock_select[g] <= logic_unit_pkg::FCLK_SEL_RESET;
        else if (hitUnit && regAddr[1:0] == logic_unit_pkg::OFS_CLOCK)
          flop_clock_select[g] <= regWrData[logic_unit_pkg::FCLK_SEL_LSB +:
                                 logic_unit_pkg::FCLK_SEL_W];
      end

      always_ff @(posedge core_clk)
      begin
        if (srst)
          control[g] <= logic_unit_pkg::CONTROL_RESET;
        else if (hitUnit &&
                 regAddr[1:0] == logic_unit_pkg::OFS_CONTROL)
          control[g] <= regWrData[logic_unit_pkg::CTL_W-1:0];
      end

      // 16-way input selectors
      assign inA[g] = candidates[inputSel[g][logic_unit_pkg::SEL_A_LSB +:
                                            logic_unit_pkg::SEL_W]];
      assign inB[g] = candidates[inputSel[g][logic_unit_pkg::SEL_B_LSB +:
                                            logic_unit_pkg::SEL_W]];

      // Table lookup: every index hits a stored bit, so the result is
      // always 0 or 1
      assign lutOut[g] = funcByte[g][{inA[g], inB[g], carry[g]}];

      // Flop clock-source decode; sources other than the core clock are
      // rising edges seen at core_clk rate
      always_comb
      begin
        case (logic_unit_pkg::flop_clock_select_t'(flop_clock_select[g]))
          logic_unit_pkg::CLK_CORE:
            flopTick[g] = 1'b1;
          logic_unit_pkg::CLK_A_RISE:
            flopTick[g] = inA[g] & ~prevA[g];
          logic_unit_pkg::CLK_B_RISE:
            flopTick[g] = inB[g] & ~prevB[g];
          logic_unit_pkg::CLK_CARRY_RISE:
            flopTick[g] = carry[g] & ~prevCarry[g];
          default:
            flopTick[g] = 1'b0;
        endcase
      end

      always_ff @(posedge core_clk)
      begin
        if (srst)
        begin
          prevA[g] <= 1'b0;
          prevB[g] <= 1'b0;
          prevCarry[g] <= 1'b0;
        end
        else
        begin
          prevA[g] <= inA[g];
          prevB[g] <= inB[g];
          prevCarry[g] <= carry[g];
        end
      end

      always_ff @(posedge core_clk)
      begin
        if (srst)
          flopQ[g] <= 1'b0;
        else if (flopTick[g])
          flopQ[g] <= lutOut[g];
      end

      // Bypass presents the table result; latches rely on it
      assign unitOut[g] = control[g][logic_unit_pkg::CTL_BYPASS] ?
        lutOut[g] : flopQ[g];

      always_ff @(posedge core_clk)
      begin
        if (srst)
        begin
          outHeld[g] <= 1'b0;
          lutHeld[g] <= 1'b0;
        end
        else
        begin
          outHeld[g] <= unitOut[g];
          lutHeld[g] <= lutOut[g];
        end
      end

      // Routed outputs come from flops, one cycle behind unitOut
      always_ff @(posedge core_clk)
      begin
        if (srst)
        begin
          pinOut[g] <= 1'b0;
          pinOe[g] <= 1'b0;
          periphOut[g] <= 1'b0;
        end
        else
        begin
          pinOut[g] <= unitOut[g];
          pinOe[g] <= control[g][logic_unit_pkg::CTL_PIN_EN];
          periphOut[g] <= unitOut[g] &
                          control[g][logic_unit_pkg::CTL_PERIPH_EN];
        end
      end
    end
  endgenerate

  assign statusWord = {flopQ, outHeld};

  // Read decode; unmapped addresses answer zero
  always_comb
  begin
    next_rdData = 8'h00;
    if (regAddr == logic_unit_pkg::ADDR_STATUS)
      next_rdData = statusWord;
    else if (regAddr < logic_unit_pkg::ADDR_STATUS)
    begin
      case (regAddr[1:0])
        logic_unit_pkg::OFS_FUNCTION:
          next_rdData = funcByte[regAddr[3:2]];
        logic_unit_pkg::OFS_CONFIG:
          next_rdData = inputSel[regAddr[3:2]];
        logic_unit_pkg::OFS_CLOCK:
          next_rdData = {6'h00, flop_clock_select[regAddr[3:2]]};
        logic_unit_pkg::OFS_CONTROL:
          next_rdData = {5'h00, control[regAddr[3:2]]};
        default:
          next_rdData = 8'h00;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (srst)
      regRdData <= 8'h00;
    else if (regRead)
      regRdData <= next_rdData;
    else
      regRdData <= 8'h00;
  end

endmodule : configurable_logic_module

// >>> design/logic_unit_pkg.sv
// Shared constants for the configurable logic module: register map,
// field positions, reset values and the flop clock-source encoding.
// Assumes a single core clock and a plain strobe-based register port.
package logic_unit_pkg;

  localparam int NUM_UNITS = 4;
  localparam int PIN_COUNT = 8;
  localparam int PERIPH_COUNT = 4;
  localparam int ADDR_W = 5;

  // Per-unit block of four registers; unit u starts at u * UNIT_STRIDE
  localparam logic [ADDR_W-1:0] UNIT_STRIDE = 5'h04;
  localparam logic [1:0] OFS_FUNCTION = 2'h0;
  localparam logic [1:0] OFS_CONFIG = 2'h1;
  localparam logic [1:0] OFS_CLOCK = 2'h2;
  localparam logic [1:0] OFS_CONTROL = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h10;

  // Input selector fields in the config register
  localparam int SEL_A_LSB = 0;
  localparam int SEL_B_LSB = 4;
  localparam int SEL_W = 4;
  // Clock select field in the clock register
  localparam int FCLK_SEL_LSB = 0;
  localparam int FCLK_SEL_W = 2;
  // Control register bits
  localparam int CTL_BYPASS = 0;
  localparam int CTL_PIN_EN = 1;
  localparam int CTL_PERIPH_EN = 2;
  localparam int CTL_W = 3;
  // Status register fields
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_FLOP_LSB = 4;

  // Selector candidate ranges: pins, then unit outputs, then peripherals
  localparam logic [3:0] SEL_UNIT_BASE = 4'h8;
  localparam logic [3:0] SEL_PERIPH_BASE = 4'hC;

  // Reset values
  localparam logic [7:0] FUNCTION_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [FCLK_SEL_W-1:0] FCLK_SEL_RESET = 2'h0;
  localparam logic [CTL_W-1:0] CONTROL_RESET = 3'h0;

  typedef enum logic [1:0] {
    CLK_CORE = 2'b00,
    CLK_A_RISE = 2'b01,
    CLK_B_RISE = 2'b10,
    CLK_CARRY_RISE = 2'b11
  } flop_clock_select_t;

endpackage : logic_unit_pkg

// >>> verification/logic_unit_monitor.sv
// Checker for the register port and output routing of the logic module.
// Bound to the top module; sees its ports only.
module logic_unit_monitor
(
  // Clock, reset and register port
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Unit outputs
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  input wire logic [3:0] periphOut
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (srst);
  logic ctlWr;
  assign ctlWr = regWrite && regAddr < 5'h10 && regAddr[1:0] == 2'h3;
  // Write followed at once by a read of the same place
  sequence wr_rd(logic [1:0] o);
    regWrite && regAddr < 5'h10 && regAddr[1:0] == o
      ##1 regRead && regAddr == $past(regAddr);
  endsequence
  reset_clear_a: assert property ($fell(srst) |->
    (pinOut | pinOe | periphOut) == 4'h0) else $error("not clear");
  func_back_a: assert property (wr_rd(2'h0) |=>
    regRdData == $past(regWrData, 2)) else $error("function byte");
  sel_back_a: assert property (wr_rd(2'h1) |=>
    regRdData == $past(regWrData, 2)) else $error("selectors");
  ctl_back_a: assert property (wr_rd(2'h3) |=>
    regRdData[2:0] == $past(regWrData[2:0], 2)) else $error("control");
  stat_out_a: assert property (regRead && regAddr == 5'h10 |=>
    regRdData[3:0] == $past(pinOut)) else $error("status");
  rd_idle_a: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read idle");
  periph_gate_a: assert property ((periphOut & ~pinOut) == 4'h0)
    else $error("periph gate");
  pin_enable_a: assert property (ctlWr ##1 !ctlWr [*2] |->
    pinOe[$past(regAddr[3:2], 2)] == $past(regWrData[1], 2))
    else $error("pin enable");
endmodule : logic_unit_monitor

bind configurable_logic_module logic_unit_monitor mon (.core_clk, .srst,
  .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .pinOut, .pinOe,
  .periphOut);

// >>> verification/pin_side_model.sv
// Pin and peripheral side: pins 7-4 are wired back from the unit pins.
// Assumes the bench sets pins 3-0; undriven pins have a pull-down.
module pin_side_model
(
  // Clock and bench levels
  input wire logic core_clk,
  input wire logic [3:0] cmdPins,
  // Block outputs
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  input wire logic [3:0] periphOut,
  // Block inputs
  output logic [7:0] pinIn,
  output logic [3:0] periphIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin falls to its pull-down, not to its last level
  assign pinIn = {pinOut & pinOe, cmdPins};
  // Peripheral that latches what is routed to it; settles during reset
  always @(posedge core_clk)
  begin
    periphIn <= periphOut;
  end
endmodule : pin_side_model

// >>> verification/test_configurable_logic_module.sv
// Bench: register access, table index, both latches, flop clock select.
// Assumes pin changes reach the unit pins within 12 clocks.
`define CHK(a, e) chk(8'(a), 8'(e))
module test_configurable_logic_module;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] regAddr = 5'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [3:0] cmdPins = 4'h0;
  logic [7:0] regRdData, pinIn, f;
  logic [3:0] periphIn, pinOut, pinOe, periphOut;
  logic [7:0] srByte [4] = '{8'h74, 8'hF4, 8'hD4, 8'h54};
  logic [3:0] dlPin [6] = '{4'h5, 4'h0, 4'h1, 4'h4, 4'h5, 4'h0};
  logic [5:0] dlExp = 6'b110011;
  int n_fail = 0;
  int compares = 0;
  configurable_logic_module uut (.core_clk, .srst, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .pinIn, .periphIn, .pinOut, .pinOe,
    .periphOut);
  pin_side_model pins (.core_clk, .cmdPins, .pinOut, .pinOe, .periphOut,
    .pinIn, .periphIn);
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    compares++;
    if (a !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    `CHK(regRdData, e);
  endtask : rd
  // Read straight after the write, with no gap, to reach the checker
  task automatic wrrd(input logic [4:0] a, input logic [7:0] d);
    wr(a, d);
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    `CHK(regRdData, d);
  endtask : wrrd
  task automatic step(input logic [3:0] p);
    @(posedge core_clk);
    cmdPins <= p;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
  endtask : step
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    for (int u = 0; u < 5; u++)
      rd(5'(4 * u), 8'h00);
    wr(5'h15, 8'hFF);
    rd(5'h15, 8'h00);
    for (int u = 0; u < 4; u++)
    begin
      wrrd(5'(4 * u + 1), 8'(8'hC3 + u));
      wrrd(5'(4 * u + 2), 8'(u));
    end
    // Unit 0 buffers pin 2 onto the carry of unit 1
    wrrd(5'h00, 8'hF0);
    wrrd(5'h01, 8'h02);
    wrrd(5'h05, 8'h10);
    wrrd(5'h07, 8'h03);
    wrrd(5'h04, 8'hB2);
    f = 8'hB2;
    for (int c = 0; c < 8; c++)
    begin
      step({1'b0, c[0], c[1], c[2]});
      `CHK(pinOut[1], f[c]);
    end
    // Second input of unit 1 is its own output
    wrrd(5'h05, 8'h90);
    for (int i = 0; i < 4; i++)
    begin
      f = srByte[i];
      wrrd(5'h04, f);
      step(4'h4);
      `CHK(pinOut[1], 1'b0);
      step(4'h1);
      `CHK(pinOut[1], 1'b1);
      step(4'h0);
      `CHK(pinOut[1], 1'b1);
      step(4'h4);
      step(4'h0);
      `CHK(pinOut[1], 1'b0);
      // The first byte toggles with both inputs high, so it is skipped
      if (i > 0)
      begin
        step(4'h5);
        `CHK(pinOut[1], f[5] & f[7]);
      end
    end
    wr(5'h09, 8'h02);
    wrrd(5'h08, 8'hF0);
    wr(5'h0D, 8'hB0);
    wr(5'h0F, 8'h03);
    wrrd(5'h0C, 8'hAC);
    for (int i = 0; i < 6; i++)
    begin
      step(dlPin[i]);
      `CHK(pinOut[3], dlExp[i]);
    end
    wr(5'h01, 8'h12);
    wrrd(5'h02, 8'(logic_unit_pkg::CLK_B_RISE));
    wrrd(5'h03, 8'h06);
    step(4'h4);
    `CHK(pinOut[0], 1'b0);
    step(4'h6);
    `CHK(pinOut[0], 1'b1);
    `CHK(periphOut[0], 1'b1);
    step(4'h0);
    `CHK(pinOut[0], 1'b1);
    step(4'h2);
    `CHK(pinOut[0], 1'b0);
    report_and_stop();
  end
endmodule : test_configurable_logic_module
